// ==== sccg_baud_gen.sv ====
// baud rate divider: integer N or N + (16-K)/16 on input ticks
// assumes tick_in is a one-cycle pulse in the hclk domain

module sccg_baud_gen (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // control
    input  wire logic       run,
    input  wire logic [3:0] div_n,
    input  wire logic [3:0] div_k,
    input  wire logic       frac_en,
    // ticks
    input  wire logic       tick_in,
    output logic            tick_out
);
    import sccg_pkg::*;

    logic [4:0] count_reg;
    logic [3:0] phase_reg;
    logic [4:0] n_full;
    logic [4:0] target;
    logic       stretch;

    // ------------------------------------------------------------
    // divide target
    // ------------------------------------------------------------
    assign n_full  = (div_n == 4'h0) ? 5'h10 : {1'b0, div_n};
    // stretch 16-K of every 16 output periods by one input tick
    assign stretch = frac_en && ({1'b0, phase_reg} < (5'h10 - {1'b0, div_k}));
    assign target  = stretch ? 5'(n_full + 5'h01) : n_full;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= 5'h00;
            phase_reg <= 4'h0;
            tick_out  <= 1'b0;
        end else if (!run) begin
            count_reg <= 5'h00;
            phase_reg <= 4'h0;
            tick_out  <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if (5'(count_reg + 5'h01) >= target) begin
                    count_reg <= 5'h00;
                    phase_reg <= 4'(phase_reg + 4'h1);
                    tick_out  <= 1'b1;
                end else begin
                    count_reg <= 5'(count_reg + 5'h01);
                end
            end
        end
    end

endmodule : sccg_baud_gen

// ==== sccg_peer.sv ====
// far-side peer driving the external shift clock pin
// assumes a 50 ns system clock; period is two half spans
module sccg_peer (
    // control
    input  wire logic       run,
    input  wire logic [7:0] half,
    // pin
    output logic            sclk
);
    timeunit 1ns;
    timeprecision 1ns;
    initial sclk = 1'b1;
    // stands high outside frames
    always begin
        if (run) begin
            #(half * 50) sclk = ~sclk;
        end else begin
            sclk = 1'b1;
            #13;
        end
    end
endmodule : sccg_peer

// ==== sccg_pkg.sv ====
// package for the serial channel clock generator
// assumes a single system clock domain and an AHB-Lite register port

package sccg_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SCCG_BAUD_CONTROL_OFF  = 8'h00;
    localparam logic [7:0] SCCG_BAUD_FRACTION_OFF = 8'h04;
    localparam logic [7:0] SCCG_MODE0_OFF         = 8'h08;
    localparam logic [7:0] SCCG_CONTROL_OFF       = 8'h0C;
    localparam logic [7:0] SCCG_TIMER_MATCH_OFF   = 8'h10;
    localparam logic [7:0] SCCG_STATUS_OFF        = 8'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SCCG_DIV_N_LSB      = 0;
    localparam int SCCG_BRG_SEL_LSB    = 4;
    localparam int SCCG_FRAC_EN_BIT    = 6;
    localparam int SCCG_DIV_K_LSB      = 0;
    localparam int SCCG_MODE_BIT       = 0;
    localparam int SCCG_UART_SEL_LSB   = 1;
    localparam int SCCG_DBUF_BIT       = 3;
    localparam int SCCG_CLK_IN_BIT     = 0;
    localparam int SCCG_EDGE_BIT       = 1;
    localparam int SCCG_ST_CFG_ERR_BIT = 0;
    localparam int SCCG_ST_SCLK_BIT    = 1;
    localparam int SCCG_ST_TOGGLE_BIT  = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  SCCG_DIV_N_RST       = 4'h2;
    localparam logic [1:0]  SCCG_BRG_SEL_RST     = 2'h0;
    localparam logic [3:0]  SCCG_DIV_K_RST       = 4'h0;
    localparam logic [1:0]  SCCG_UART_SEL_RST    = 2'h1;
    localparam logic [15:0] SCCG_TIMER_MATCH_RST = 16'h0001;

    // ------------------------------------------------------------
    // timing counts: prescaler taps in system clock cycles, UART oversample in transfer clock pulses
    // ------------------------------------------------------------
    localparam int SCCG_TAP_DIV_0      = 2;
    localparam int SCCG_TAP_DIV_1      = 8;
    localparam int SCCG_TAP_DIV_2      = 32;
    localparam int SCCG_TAP_DIV_3      = 128;
    localparam int SCCG_UART_OVERSAMPLE = 16;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SCCG_SRC_TIMER = 2'h0,
        SCCG_SRC_BRG   = 2'h1,
        SCCG_SRC_FSYS  = 2'h2,
        SCCG_SRC_SCLK  = 2'h3
    } sccg_uart_src_type;

endpackage : sccg_pkg

// ==== sccg_top.sv ====
// serial channel clock generator with AHB-Lite register port
// assumes one system clock hclk; sclk pin is asynchronous to it
//
// Notes on behaviour
// - the generator input is one of four prescaler taps, system clock over 2, 8, 32 or 128.
// - in shift-clock mode the generator divides only by an integer N from 1 to 16.
// - in UART mode a divide enable picks plain N or N + (16-K)/16 with N 2..15, K 1..15.
// - N of one is allowed only with double buffering, otherwise two is the minimum.
// - a mode field picks shift-clock or UART, each with its own clock source controls.
// - a driven-out shift clock is the generator output over two and needs rising edge select.
// - in shift-clock mode an external shift clock is used on its rising or falling edge as edge select says.
// - in UART mode the transfer clock is divided by 16 so one bit spans 16 pulses.
// - in UART mode the source is timer toggle, generator, system clock or external clock.
// - the timer flip-flop toggles on each match of its counter with the match value.
// - a prescaler tap faster than half the system clock is treated as prohibited.

module sccg_top
    import sccg_pkg::*;
#(
    parameter int TIMER_WIDTH = 16
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // shift clock pin
    input  wire logic        sclk_in,
    output logic             sclk_out,
    output logic             sclk_oe,
    // transfer clock outputs
    output logic             serial_transfer_clock,
    output logic             bit_tick,
    output logic             config_error
);
    import sccg_pkg::*;

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (TIMER_WIDTH < 2 || TIMER_WIDTH > 16) begin : g_bad_width
        $error("timer width must be 2 to 16");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [3:0]             div_n_reg;
    logic [1:0]             brg_input_select;
    logic                   frac_en_reg;
    logic [3:0]             div_k_reg;
    logic                   serial_mode_select;
    logic [1:0]             uart_clock_select;
    logic                   dbuf_en_reg;
    logic                   clk_in_reg;
    logic                   edge_sel_reg;
    logic [TIMER_WIDTH-1:0] timer_match_value;

    logic                   wr_pend_reg;
    logic [7:0]             wr_addr_reg;
    logic                   addr_phase;
    logic [31:0]            rd_value;

    logic [6:0]             presc_reg;
    logic                   tap_tick;
    logic                   prescaler_tap_one;

    logic [TIMER_WIDTH-1:0] timer_cnt_reg;
    logic                   timer_ff_reg;
    logic                   timer_ff_dly_reg;
    logic                   timer_tick;

    logic                   sclk_sync1_reg;
    logic                   sclk_sync2_reg;
    logic                   sclk_sync3_reg;
    logic                   sclk_rise;
    logic                   sclk_fall;

    logic                   brg_run;
    logic                   brg_tick;
    logic                   cfg_bad;
    logic                   src_tick;
    logic [3:0]             bit_cnt_reg;

    // ------------------------------------------------------------
    // register access helpers
    // ------------------------------------------------------------
    function automatic logic is_word_offset(input logic [7:0] off);
        is_word_offset = (off == SCCG_BAUD_CONTROL_OFF) || (off == SCCG_BAUD_FRACTION_OFF)
                      || (off == SCCG_MODE0_OFF) || (off == SCCG_CONTROL_OFF)
                      || (off == SCCG_TIMER_MATCH_OFF) || (off == SCCG_STATUS_OFF);
    endfunction : is_word_offset

    function automatic logic tap_hit(input logic [6:0] cnt, input int div);
        tap_hit = (cnt & 7'(div - 1)) == 7'(div - 1);
    endfunction : tap_hit

    // ------------------------------------------------------------
    // ahb-lite address phase
    // ------------------------------------------------------------
    assign addr_phase = hsel && htrans[1] && hready;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_phase && hwrite && is_word_offset(haddr[7:0])
                           && (haddr[31:8] == 24'h000000);
            wr_addr_reg <= haddr[7:0];
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_n_reg          <= SCCG_DIV_N_RST;
            brg_input_select   <= SCCG_BRG_SEL_RST;
            frac_en_reg        <= 1'b0;
            div_k_reg          <= SCCG_DIV_K_RST;
            serial_mode_select <= 1'b0;
            uart_clock_select  <= SCCG_UART_SEL_RST;
            dbuf_en_reg        <= 1'b0;
            clk_in_reg         <= 1'b0;
            edge_sel_reg       <= 1'b0;
            timer_match_value  <= TIMER_WIDTH'(SCCG_TIMER_MATCH_RST);
        end else if (wr_pend_reg) begin
            unique case (wr_addr_reg)
                SCCG_BAUD_CONTROL_OFF: begin
                    div_n_reg        <= hwdata[SCCG_DIV_N_LSB +: 4];
                    brg_input_select <= hwdata[SCCG_BRG_SEL_LSB +: 2];
                    frac_en_reg      <= hwdata[SCCG_FRAC_EN_BIT];
                end
                SCCG_BAUD_FRACTION_OFF: begin
                    div_k_reg <= hwdata[SCCG_DIV_K_LSB +: 4];
                end
                SCCG_MODE0_OFF: begin
                    serial_mode_select <= hwdata[SCCG_MODE_BIT];
                    uart_clock_select  <= hwdata[SCCG_UART_SEL_LSB +: 2];
                    dbuf_en_reg        <= hwdata[SCCG_DBUF_BIT];
                end
                SCCG_CONTROL_OFF: begin
                    clk_in_reg   <= hwdata[SCCG_CLK_IN_BIT];
                    edge_sel_reg <= hwdata[SCCG_EDGE_BIT];
                end
                SCCG_TIMER_MATCH_OFF: begin
                    timer_match_value <= hwdata[TIMER_WIDTH-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    always_comb begin
        rd_value = 32'h00000000;
        unique case (haddr[7:0])
            SCCG_BAUD_CONTROL_OFF: begin
                rd_value[SCCG_DIV_N_LSB +: 4]   = div_n_reg;
                rd_value[SCCG_BRG_SEL_LSB +: 2] = brg_input_select;
                rd_value[SCCG_FRAC_EN_BIT]      = frac_en_reg;
            end
            SCCG_BAUD_FRACTION_OFF: begin
                rd_value[SCCG_DIV_K_LSB +: 4] = div_k_reg;
            end
            SCCG_MODE0_OFF: begin
                rd_value[SCCG_MODE_BIT]          = serial_mode_select;
                rd_value[SCCG_UART_SEL_LSB +: 2] = uart_clock_select;
                rd_value[SCCG_DBUF_BIT]          = dbuf_en_reg;
            end
            SCCG_CONTROL_OFF: begin
                rd_value[SCCG_CLK_IN_BIT] = clk_in_reg;
                rd_value[SCCG_EDGE_BIT]   = edge_sel_reg;
            end
            SCCG_TIMER_MATCH_OFF: begin
                rd_value[TIMER_WIDTH-1:0] = timer_match_value;
            end
            SCCG_STATUS_OFF: begin
                rd_value[SCCG_ST_CFG_ERR_BIT] = cfg_bad;
                rd_value[SCCG_ST_SCLK_BIT]    = sclk_sync2_reg;
                rd_value[SCCG_ST_TOGGLE_BIT]  = timer_ff_reg;
            end
            default: begin
            end
        endcase
        if (haddr[31:8] != 24'h000000) begin
            rd_value = 32'h00000000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= rd_value;
        end
    end

    // ------------------------------------------------------------
    // prescaler taps
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_reg <= 7'h00;
        end else begin
            presc_reg <= 7'(presc_reg + 7'h01);
        end
    end

    // fastest tap is fsys/2, so no prohibited tap rate exists
    assign prescaler_tap_one = tap_hit(presc_reg, SCCG_TAP_DIV_0);

    always_comb begin
        unique case (brg_input_select)
            2'h0:    tap_tick = prescaler_tap_one;
            2'h1:    tap_tick = tap_hit(presc_reg, SCCG_TAP_DIV_1);
            2'h2:    tap_tick = tap_hit(presc_reg, SCCG_TAP_DIV_2);
            default: tap_tick = tap_hit(presc_reg, SCCG_TAP_DIV_3);
        endcase
    end

    // ------------------------------------------------------------
    // configuration check
    // ------------------------------------------------------------
    always_comb begin
        cfg_bad = 1'b0;
        if (div_n_reg == 4'h1 && !dbuf_en_reg) begin
            cfg_bad = 1'b1;
        end
        if (serial_mode_select && frac_en_reg) begin
            if (div_n_reg < 4'h2 || div_k_reg == 4'h0) begin
                cfg_bad = 1'b1;
            end
        end
        if (!serial_mode_select && !clk_in_reg && edge_sel_reg) begin
            cfg_bad = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // baud rate generator
    // ------------------------------------------------------------
    assign brg_run = !cfg_bad;

    sccg_baud_gen u_baud_gen (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .run      (brg_run),
        .div_n    (div_n_reg),
        .div_k    (div_k_reg),
        .frac_en  (serial_mode_select && frac_en_reg),
        .tick_in  (tap_tick),
        .tick_out (brg_tick)
    );

    // ------------------------------------------------------------
    // timer toggle source
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_cnt_reg    <= '0;
            timer_ff_reg     <= 1'b0;
            timer_ff_dly_reg <= 1'b0;
        end else begin
            timer_ff_dly_reg <= timer_ff_reg;
            if (prescaler_tap_one) begin
                if (timer_cnt_reg >= timer_match_value) begin
                    timer_cnt_reg <= '0;
                    timer_ff_reg  <= !timer_ff_reg;
                end else begin
                    timer_cnt_reg <= TIMER_WIDTH'(timer_cnt_reg + 1'b1);
                end
            end
        end
    end

    assign timer_tick = timer_ff_reg && !timer_ff_dly_reg;

    // ------------------------------------------------------------
    // external shift clock synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_sync1_reg <= 1'b1;
            sclk_sync2_reg <= 1'b1;
            sclk_sync3_reg <= 1'b1;
        end else begin
            sclk_sync1_reg <= sclk_in;
            sclk_sync2_reg <= sclk_sync1_reg;
            sclk_sync3_reg <= sclk_sync2_reg;
        end
    end

    // peer keeps the clock slow enough to be seen
    assign sclk_rise = sclk_sync2_reg && !sclk_sync3_reg;
    assign sclk_fall = !sclk_sync2_reg && sclk_sync3_reg;

    // ------------------------------------------------------------
    // shift clock output
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_out <= 1'b1;
            sclk_oe  <= 1'b0;
        end else begin
            sclk_oe <= !serial_mode_select && !clk_in_reg;
            if (serial_mode_select || clk_in_reg || cfg_bad) begin
                sclk_out <= 1'b1;
            end else if (brg_tick) begin
                sclk_out <= !sclk_out;
            end
        end
    end

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    always_comb begin
        src_tick = 1'b0;
        if (cfg_bad) begin
            src_tick = 1'b0;
        end else if (!serial_mode_select) begin
            if (!clk_in_reg) begin
                src_tick = brg_tick && !sclk_out;
            end else begin
                src_tick = edge_sel_reg ? sclk_fall : sclk_rise;
            end
        end else begin
            unique case (sccg_uart_src_type'(uart_clock_select))
                SCCG_SRC_TIMER: src_tick = timer_tick;
                SCCG_SRC_BRG:   src_tick = brg_tick;
                SCCG_SRC_FSYS:  src_tick = 1'b1;
                SCCG_SRC_SCLK:  src_tick = sclk_rise;
            endcase
        end
    end

    // ------------------------------------------------------------
    // transfer clock and bit divider
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_transfer_clock <= 1'b0;
            bit_tick              <= 1'b0;
            bit_cnt_reg           <= 4'h0;
            config_error          <= 1'b0;
        end else begin
            serial_transfer_clock <= src_tick;
            config_error          <= cfg_bad;
            bit_tick              <= 1'b0;
            if (!serial_mode_select) begin
                bit_cnt_reg <= 4'h0;
                bit_tick    <= src_tick;
            end else if (src_tick) begin
                bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
                if (bit_cnt_reg == 4'(SCCG_UART_OVERSAMPLE - 1)) begin
                    bit_tick <= 1'b1;
                end
            end
        end
    end

endmodule : sccg_top

// ==== sccg_top_properties.sv ====
// port checker for the serial channel clock generator
// assumes it is bound to sccg_top and sees only its ports
module sccg_top_properties (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // clocks
    input wire logic        sclk_out,
    input wire logic        sclk_oe,
    input wire logic        serial_transfer_clock,
    input wire logic        bit_tick,
    input wire logic        config_error
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire wr_take = hsel && htrans[1] && hready && hwrite;
    sequence s_rd_unmap;
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] > 8'h14;
    endsequence
    sequence s_quiet3;
        !serial_transfer_clock [*3];
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_unmap_zero: assert property (s_rd_unmap |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_err_quiet: assert property (config_error |-> !serial_transfer_clock)
        else $error("pulse while config prohibited");
    a_err_high: assert property (config_error [*2] |-> sclk_out)
        else $error("shift clock not parked high");
    a_out_spacing: assert property (serial_transfer_clock && sclk_oe |=> s_quiet3)
        else $error("clock out pulses too close");
    a_out_toggle: assert property (sclk_oe && $changed(sclk_out) |=>
        $stable(sclk_out) || config_error || !sclk_oe)
        else $error("shift clock toggles too fast");
    a_tick_single: assert property (bit_tick |=> !bit_tick)
        else $error("bit tick longer than one cycle");
    a_err_cause: assert property ($changed(config_error) |->
        $past(wr_take, 2) || $past(wr_take, 3))
        else $error("config error moved without a write");
endmodule : sccg_top_properties

bind sccg_top sccg_top_properties chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .hrdata, .sclk_out, .sclk_oe, .serial_transfer_clock,
    .bit_tick, .config_error);

// ==== sccg_top_tb.sv ====
// testbench for the serial channel clock generator
// assumes sccg_pkg, sccg_top, the checker and sccg_peer compiled first
module sccg_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sccg_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [7:0] half = 8'h0A;
    logic hreadyout, hresp, sclk_in, sclk_out, sclk_oe, stc, bit_tick, config_error;
    logic sel_bt = 1'b0;
    int error_cnt = 0, n_checks = 0, g;
    wire pick = sel_bt ? bit_tick : stc;
    always #25 hclk = ~hclk;
    sccg_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .serial_transfer_clock(stc), .bit_tick(bit_tick), .config_error(config_error));
    sccg_peer peer (.run(run), .half(half), .sclk(sclk_in));
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    task automatic chk_v(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk_v
    task automatic chk_r(input int got, input int lo, input int hi, input string m);
        n_checks++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("BAD %0t %s got %0d", $time, m, got);
        end
    endtask : chk_r
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic cfg(input logic [31:0] b, k, m, c, t);
        bus(1'b1, 8'h00, b);
        bus(1'b1, 8'h04, k);
        bus(1'b1, 8'h08, m);
        bus(1'b1, 8'h0C, c);
        bus(1'b1, 8'h10, t);
    endtask : cfg
    task automatic gap(output int n);
        n = 0;
        repeat (2) do @(negedge hclk); while (pick !== 1'b1);
        do begin
            @(negedge hclk);
            n++;
        end while (pick !== 1'b1);
        @(posedge hclk);
    endtask : gap
    task automatic t_regs();
        logic [7:0] a[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
        logic [31:0] e[6] = '{32'h2, 32'h0, 32'h2, 32'h0, 32'h1, 32'h0};
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, a[i], 32'h0);
            chk_v(rd, e[i], "reset value");
        end
        bus(1'b1, 8'h20, 32'hFFFF);
        bus(1'b1, 8'h10, 32'h1234);
        bus(1'b0, 8'h20, 32'h0);
        chk_v(rd, 32'h0, "unmapped read");
        bus(1'b0, 8'h10, 32'h0);
        chk_v(rd, 32'h1234, "readback");
    endtask : t_regs
    task automatic t_shift();
        int dv[4] = '{2, 8, 32, 128};
        sel_bt = 1'b0;
        for (int i = 0; i < 4; i++) begin
            cfg(32'h1 | (i << 4), 32'h0, 32'h8, 32'h0, 32'h1);
            gap(g);
            chk_r(g, 2 * dv[i], 2 * dv[i], "shift out rate");
        end
        cfg(32'h0, 32'h0, 32'h0, 32'h0, 32'h1);
        gap(g);
        chk_r(g, 64, 64, "divide by 16");
        chk_v(sclk_oe, 32'h1, "clock out enable");
    endtask : t_shift
    task automatic t_err();
        logic [31:0] b[5] = '{32'h1, 32'h1, 32'h2, 32'h42, 32'h42};
        logic [31:0] k[5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h8};
        logic [31:0] m[5] = '{32'h0, 32'h8, 32'h0, 32'h1, 32'h1};
        logic [31:0] c[5] = '{32'h0, 32'h0, 32'h2, 32'h0, 32'h0};
        logic [31:0] e[5] = '{32'h1, 32'h0, 32'h1, 32'h1, 32'h0};
        for (int i = 0; i < 5; i++) begin
            cfg(b[i], k[i], m[i], c[i], 32'h1);
            repeat (3) @(posedge hclk);
            bus(1'b0, 8'h14, 32'h0);
            chk_v(rd & 32'h3, e[i] | 32'h2, "status error");
            chk_v(config_error, e[i], "error pin");
        end
    endtask : t_err
    task automatic t_edge();
        sel_bt = 1'b0;
        half <= 8'h0A;
        run <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            cfg(32'h2, 32'h0, 32'h0, 32'h1 | (i << 1), 32'h1);
            repeat (8) @(posedge hclk);
            @(posedge sclk_in);
            g = 0;
            do begin
                @(negedge hclk);
                g++;
            end while (stc !== 1'b1);
            @(posedge hclk);
            chk_r(g, i ? 11 : 2, i ? 16 : 6, "edge lag");
        end
        chk_v(sclk_oe, 32'h0, "input mode enable");
        run <= 1'b0;
    endtask : t_edge
    task automatic t_uart();
        logic [31:0] s[7] = '{32'h2, 32'h1, 32'h0, 32'h3, 32'h1, 32'h1, 32'h0};
        logic [31:0] b[7] = '{32'h2, 32'h2, 32'h2, 32'h2, 32'h42, 32'h42, 32'h2};
        logic [31:0] k[7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h8, 32'hF, 32'h0};
        logic [31:0] t[7] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h3};
        int e[7] = '{16, 64, 128, 64, 80, 66, 256};
        sel_bt = 1'b1;
        half <= 8'h02;
        for (int i = 0; i < 7; i++) begin
            run <= (s[i] == 32'h3);
            cfg(b[i], k[i], 32'h1 | (s[i] << 1), 32'h0, t[i]);
            gap(g);
            chk_r(g, e[i], e[i], "bit span");
        end
        run <= 1'b0;
    endtask : t_uart
    initial begin
        #3000000;
        error_cnt++;
        $display("BAD %0t watchdog", $time);
        final_report();
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_shift();
        t_err();
        t_edge();
        t_uart();
        final_report();
    end
endmodule : sccg_top_tb
